// *** hw/seq_pkg.sv ***
// shared constants and types for the instruction cycle sequencer
package seq_pkg;

	localparam int unsigned DATA_W      = 16;
	localparam logic [15:0] WORD_STEP   = 16'h0002;
	localparam logic [15:0] WORD_RST    = 16'h0000;
	localparam logic [4:0]  LAST_STEP   = 5'h0F;
	localparam logic [4:0]  STEP_RST    = 5'h00;
	localparam logic [4:0]  STEP_INC    = 5'h01;
	localparam logic [16:0] SUM_RST     = 17'h00000;

	typedef enum logic [1:0] {
		CYC_NONE  = 2'h0,
		CYC_READ  = 2'h1,
		CYC_WRITE = 2'h2,
		CYC_ALU   = 2'h3
	} cycle_type_t;

	typedef enum logic [1:0] {
		CLS_TWO_OPERAND = 2'h0,
		CLS_MULTIPLY_OP = 2'h1,
		CLS_DIVIDE      = 2'h2
	} op_class_t;

	typedef enum logic [3:0] {
		OP_ADD              = 4'h0,
		OP_SUBTRACT         = 4'h1,
		OP_COMPARE          = 4'h2,
		OP_SET_ONES         = 4'h3,
		OP_SET_ZEROS        = 4'h4,
		OP_EXCL_OR          = 4'h5,
		OP_COPY             = 4'h6,
		OP_MATCH_ONES_TEST  = 4'h7,
		OP_MATCH_ZEROS_TEST = 4'h8
	} alu_op_t;

	typedef enum logic [2:0] {
		MD_HOLD      = 3'h0,
		MD_LOAD_OPND = 3'h1,
		MD_START_MUL = 3'h2,
		MD_LOAD_HI   = 3'h3,
		MD_LOAD_LO   = 3'h4,
		MD_MUL_STEP  = 3'h5,
		MD_DIV_SHIFT = 3'h6,
		MD_DIV_SUB   = 3'h7
	} md_cmd_t;

	typedef enum logic [4:0] {
		ST_IDLE    = 5'h00,
		ST_FETCH   = 5'h01,
		ST_DECODE  = 5'h02,
		ST_SRC     = 5'h03,
		ST_SRC_ALU = 5'h04,
		ST_DST     = 5'h05,
		ST_RES_ALU = 5'h06,
		ST_RES_WR  = 5'h07,
		ST_WS_RD   = 5'h08,
		ST_M_ALU1  = 5'h09,
		ST_M_ALU2  = 5'h0A,
		ST_MUL     = 5'h0B,
		ST_OVF     = 5'h0C,
		ST_SKIP    = 5'h0D,
		ST_LO_RD   = 5'h0E,
		ST_D_ALU1  = 5'h0F,
		ST_D_ALU2  = 5'h10,
		ST_DIV_SH  = 5'h11,
		ST_DIV_TST = 5'h12,
		ST_DIV_SUB = 5'h13,
		ST_D_END   = 5'h14,
		ST_HI_WR   = 5'h15,
		ST_LO_ALU  = 5'h16,
		ST_LO_WR   = 5'h17
	} state_t;

endpackage : seq_pkg

// *** hw/two_op_alu.sv ***
// two-operand alu with byte select and byte merge
`timescale 1ns/1ps
module two_op_alu
	import seq_pkg::*;
(
	// operation
	input  alu_op_t     op,
	input  wire logic   byte_op,
	// operands
	input  wire logic [15:0] src,
	input  wire logic        src_odd,
	input  wire logic [15:0] dst,
	input  wire logic        dst_odd,
	// results
	output logic [15:0] result,
	output logic        no_write,
	output logic        flag_eq
);
	logic [15:0] a;
	logic [15:0] b;
	logic [15:0] r;

	always_comb begin
		// byte operands are aligned into the destination byte lane
		if (byte_op) begin
			a = src_odd ? {src[7:0], src[7:0]} : {src[15:8], src[15:8]};
		end else begin
			a = src;
		end
		b = dst;
		case (op)
			OP_ADD:              r = b + a;
			OP_SUBTRACT:         r = b - a;
			OP_SET_ONES:         r = b | a;
			OP_SET_ZEROS:        r = b & ~a;
			OP_EXCL_OR:          r = b ^ a;
			OP_COPY:             r = a;
			default:             r = b;
		endcase
		// only the selected byte changes, the other byte is kept
		if (byte_op) begin
			result = dst_odd ? {dst[15:8], r[7:0]} : {r[15:8], dst[7:0]};
		end else begin
			result = r;
		end
		no_write = (op == OP_COMPARE) || (op == OP_MATCH_ONES_TEST)
			|| (op == OP_MATCH_ZEROS_TEST);
		case (op)
			OP_MATCH_ONES_TEST:  flag_eq = ((a & b) == a);
			OP_MATCH_ZEROS_TEST: flag_eq = ((a & b) == WORD_RST);
			default:             flag_eq = byte_op ? (dst_odd ? (a[7:0] == b[7:0])
				: (a[15:8] == b[15:8])) : (a == b);
		endcase
	end

endmodule : two_op_alu

// *** hw/md_unit.sv ***
// shift-add multiply and restoring divide datapath
`timescale 1ns/1ps
module md_unit
	import seq_pkg::*;
(
	// clock and reset
	input  wire logic   ref_clk,
	input  wire logic   nrst,
	// command
	input  md_cmd_t     cmd,
	input  wire logic [15:0] a,
	// state
	output logic [15:0] hi,
	output logic [15:0] lo,
	output logic [15:0] step_hi,
	output logic        fits
);
	logic [15:0] opnd;
	logic        ext;
	logic [15:0] next_hi;
	logic [15:0] next_lo;
	logic [15:0] next_opnd;
	logic        next_ext;
	logic [16:0] sum;

	always_comb begin
		sum = lo[0] ? ({1'b0, hi} + {1'b0, opnd}) : {1'b0, hi};
		fits = ext || (hi >= opnd);
		next_hi = hi;
		next_lo = lo;
		next_opnd = opnd;
		next_ext = ext;
		case (cmd)
			MD_LOAD_OPND: next_opnd = a;
			MD_START_MUL: begin
				next_hi = WORD_RST;
				next_lo = a;
				next_ext = 1'b0;
			end
			MD_LOAD_HI: begin
				next_hi = a;
				next_ext = 1'b0;
			end
			MD_LOAD_LO: next_lo = a;
			MD_MUL_STEP: begin
				next_hi = sum[16:1];
				next_lo = {sum[0], lo[15:1]};
			end
			MD_DIV_SHIFT: begin
				next_ext = hi[15];
				next_hi = {hi[14:0], lo[15]};
				next_lo = {lo[14:0], 1'b0};
			end
			MD_DIV_SUB: begin
				next_hi = hi - opnd;
				next_lo = {lo[15:1], 1'b1};
				next_ext = 1'b0;
			end
			default: next_hi = hi;
		endcase
		step_hi = next_hi;
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			hi <= WORD_RST;
			lo <= WORD_RST;
			opnd <= WORD_RST;
			ext <= 1'b0;
		end else begin
			hi <= next_hi;
			lo <= next_lo;
			opnd <= next_opnd;
			ext <= next_ext;
		end
	end

endmodule : md_unit

// *** hw/instruction_cycle_sequencer.sv ***
// machine-cycle sequencer for two-operand, multiply and divide instructions
`timescale 1ns/1ps
module instruction_cycle_sequencer
	import seq_pkg::*;
(
	// clock and reset
	input  wire logic   ref_clk,
	input  wire logic   nrst,
	// instruction request
	input  wire logic   start,
	input  op_class_t   op_class,
	input  alu_op_t     alu_op,
	input  wire logic   byte_op,
	input  wire logic [15:0] pc,
	input  wire logic [15:0] ws_addr,
	output logic        busy,
	output logic        done,
	output logic        div_overflow,
	output logic        status_eq,
	output logic [15:0] instr_word,
	// data derivation engine
	output logic        derive_req,
	output logic        derive_dest,
	input  wire logic   derive_done,
	input  wire logic [15:0] derive_addr,
	input  wire logic [15:0] derive_data,
	// memory bus
	output logic [15:0] addr_bus,
	output logic [15:0] db_out,
	output logic        db_oe,
	input  wire logic [15:0] db_in,
	output cycle_type_t cycle_type
);
	state_t      state;
	state_t      next_state;
	cycle_type_t next_cycle_type;
	logic [15:0] next_addr_bus;
	logic [15:0] next_db_out;
	logic [15:0] source_data_latch;
	logic [15:0] next_source_data_latch;
	logic [15:0] next_instr_word;
	op_class_t   cls;
	op_class_t   next_cls;
	alu_op_t     op;
	alu_op_t     next_op;
	logic        is_byte;
	logic        next_is_byte;
	logic [15:0] ws;
	logic [15:0] next_ws;
	logic [15:0] src_data;
	logic [15:0] next_src_data;
	logic [15:0] src_addr;
	logic [15:0] next_src_addr;
	logic [15:0] dst_data;
	logic [15:0] next_dst_data;
	logic [15:0] dest_address;
	logic [15:0] next_dest_address;
	logic [4:0]  step;
	logic [4:0]  next_step;
	logic        ovf;
	logic        next_ovf;
	logic        next_busy;
	logic        next_done;
	logic        next_div_overflow;
	logic        next_status_eq;
	logic        next_derive_req;
	logic        next_derive_dest;
	md_cmd_t     md_cmd;
	logic [15:0] md_a;
	logic [15:0] md_hi;
	logic [15:0] md_lo;
	logic [15:0] md_step_hi;
	logic        md_fits;
	logic [15:0] alu_result;
	logic        alu_no_write;
	logic        alu_eq;
	logic [15:0] first_half;
	logic [15:0] second_half;

	two_op_alu u_alu (
		.op       (op),
		.byte_op  (is_byte),
		.src      (src_data),
		.src_odd  (src_addr[0]),
		.dst      (dst_data),
		.dst_odd  (dest_address[0]),
		.result   (alu_result),
		.no_write (alu_no_write),
		.flag_eq  (alu_eq)
	);

	md_unit u_md (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.cmd     (md_cmd),
		.a       (md_a),
		.hi      (md_hi),
		.lo      (md_lo),
		.step_hi (md_step_hi),
		.fits    (md_fits)
	);

	// multiply writes high then low, divide writes quotient then remainder
	assign first_half = (cls == CLS_DIVIDE) ? md_lo : md_hi;
	assign second_half = (cls == CLS_DIVIDE) ? md_hi : md_lo;

	always_comb begin
		next_state = state;
		next_cycle_type = cycle_type;
		next_addr_bus = addr_bus;
		next_db_out = source_data_latch;
		next_source_data_latch = source_data_latch;
		next_instr_word = instr_word;
		next_cls = cls;
		next_op = op;
		next_is_byte = is_byte;
		next_ws = ws;
		next_src_data = src_data;
		next_src_addr = src_addr;
		next_dst_data = dst_data;
		next_dest_address = dest_address;
		next_step = step;
		next_ovf = ovf;
		next_busy = busy;
		next_done = 1'b0;
		next_div_overflow = 1'b0;
		next_status_eq = status_eq;
		next_derive_req = 1'b0;
		next_derive_dest = derive_dest;
		md_cmd = MD_HOLD;
		md_a = WORD_RST;
		case (state)
			ST_IDLE: begin
				next_cycle_type = CYC_NONE;
				if (start) begin
					next_cls = op_class;
					next_op = alu_op;
					next_is_byte = byte_op;
					next_ws = ws_addr;
					next_busy = 1'b1;
					next_state = ST_FETCH;
					next_cycle_type = CYC_READ;
					next_addr_bus = pc;
				end
			end
			ST_FETCH: begin
				next_instr_word = db_in;
				next_state = ST_DECODE;
				next_cycle_type = CYC_ALU;
			end
			ST_DECODE: begin
				next_state = ST_SRC;
				next_cycle_type = CYC_NONE;
				next_derive_req = 1'b1;
				next_derive_dest = 1'b0;
			end
			ST_SRC: begin
				next_cycle_type = CYC_NONE;
				if (derive_done) begin
					next_src_data = derive_data;
					next_src_addr = derive_addr;
					md_cmd = MD_LOAD_OPND;
					md_a = derive_data;
					next_addr_bus = derive_addr;
					next_state = ST_SRC_ALU;
					next_cycle_type = CYC_ALU;
				end
			end
			ST_SRC_ALU: begin
				if (cls == CLS_TWO_OPERAND) begin
					next_state = ST_DST;
					next_cycle_type = CYC_NONE;
					next_derive_req = 1'b1;
					next_derive_dest = 1'b1;
				end else begin
					next_dest_address = ws;
					next_state = ST_WS_RD;
					next_cycle_type = CYC_READ;
					next_addr_bus = ws;
				end
			end
			ST_DST: begin
				next_cycle_type = CYC_NONE;
				if (derive_done) begin
					next_dst_data = derive_data;
					next_dest_address = derive_addr;
					next_addr_bus = derive_addr;
					next_state = ST_RES_ALU;
					next_cycle_type = CYC_ALU;
				end
			end
			ST_RES_ALU: begin
				next_state = ST_RES_WR;
				next_addr_bus = dest_address;
				next_status_eq = alu_eq;
				if (alu_no_write) begin
					next_cycle_type = CYC_ALU;
				end else begin
					next_cycle_type = CYC_WRITE;
					next_db_out = alu_result;
					next_source_data_latch = alu_result;
				end
			end
			ST_WS_RD: begin
				next_cycle_type = CYC_ALU;
				if (cls == CLS_DIVIDE) begin
					md_cmd = MD_LOAD_HI;
					md_a = db_in;
					next_state = ST_OVF;
					next_db_out = src_data;
					next_source_data_latch = src_data;
				end else begin
					md_cmd = MD_START_MUL;
					md_a = db_in;
					next_state = ST_M_ALU1;
				end
			end
			ST_M_ALU1: begin
				next_state = ST_M_ALU2;
				next_cycle_type = CYC_ALU;
				next_db_out = src_data;
				next_source_data_latch = src_data;
			end
			ST_M_ALU2: begin
				next_state = ST_MUL;
				next_cycle_type = CYC_ALU;
				next_step = STEP_RST;
				next_db_out = md_hi;
			end
			ST_MUL: begin
				md_cmd = MD_MUL_STEP;
				next_db_out = md_step_hi;
				next_source_data_latch = md_step_hi;
				next_step = step + STEP_INC;
				if (step == LAST_STEP) begin
					next_state = ST_D_END;
				end
			end
			ST_OVF: begin
				next_ovf = md_fits;
				next_state = ST_SKIP;
				next_cycle_type = CYC_ALU;
			end
			ST_SKIP: begin
				if (ovf) begin
					next_state = ST_IDLE;
					next_cycle_type = CYC_NONE;
					next_busy = 1'b0;
					next_done = 1'b1;
					next_div_overflow = 1'b1;
				end else begin
					next_state = ST_LO_RD;
					next_cycle_type = CYC_READ;
					next_addr_bus = dest_address + WORD_STEP;
				end
			end
			ST_LO_RD: begin
				md_cmd = MD_LOAD_LO;
				md_a = db_in;
				next_state = ST_D_ALU1;
				next_cycle_type = CYC_ALU;
			end
			ST_D_ALU1: begin
				next_state = ST_D_ALU2;
			end
			ST_D_ALU2: begin
				next_state = ST_DIV_SH;
				next_step = STEP_RST;
			end
			ST_DIV_SH: begin
				md_cmd = MD_DIV_SHIFT;
				next_state = ST_DIV_TST;
			end
			ST_DIV_TST: begin
				if (md_fits) begin
					next_state = ST_DIV_SUB;
				end else begin
					next_step = step + STEP_INC;
					next_state = (step == LAST_STEP) ? ST_D_END : ST_DIV_SH;
				end
			end
			ST_DIV_SUB: begin
				md_cmd = MD_DIV_SUB;
				next_step = step + STEP_INC;
				next_state = (step == LAST_STEP) ? ST_D_END : ST_DIV_SH;
			end
			ST_D_END: begin
				next_state = ST_HI_WR;
				next_cycle_type = CYC_WRITE;
				next_addr_bus = dest_address;
				next_db_out = first_half;
				next_source_data_latch = first_half;
			end
			ST_HI_WR: begin
				next_state = ST_LO_ALU;
				next_cycle_type = CYC_ALU;
				next_addr_bus = dest_address + WORD_STEP;
				next_db_out = first_half;
			end
			ST_LO_ALU: begin
				next_state = ST_LO_WR;
				next_cycle_type = CYC_WRITE;
				next_db_out = second_half;
				next_source_data_latch = second_half;
			end
			ST_RES_WR, ST_LO_WR: begin
				next_state = ST_IDLE;
				next_cycle_type = CYC_NONE;
				next_busy = 1'b0;
				next_done = 1'b1;
			end
			default: begin
				next_state = ST_IDLE;
				next_cycle_type = CYC_NONE;
				next_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state <= ST_IDLE;
			cycle_type <= CYC_NONE;
			addr_bus <= WORD_RST;
			db_out <= WORD_RST;
			db_oe <= 1'b0;
			source_data_latch <= WORD_RST;
			instr_word <= WORD_RST;
			cls <= CLS_TWO_OPERAND;
			op <= OP_ADD;
			is_byte <= 1'b0;
			ws <= WORD_RST;
			src_data <= WORD_RST;
			src_addr <= WORD_RST;
			dst_data <= WORD_RST;
			dest_address <= WORD_RST;
			step <= STEP_RST;
			ovf <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			div_overflow <= 1'b0;
			status_eq <= 1'b0;
			derive_req <= 1'b0;
			derive_dest <= 1'b0;
		end else begin
			state <= next_state;
			cycle_type <= next_cycle_type;
			addr_bus <= next_addr_bus;
			db_out <= next_db_out;
			db_oe <= (next_cycle_type == CYC_WRITE);
			source_data_latch <= next_source_data_latch;
			instr_word <= next_instr_word;
			cls <= next_cls;
			op <= next_op;
			is_byte <= next_is_byte;
			ws <= next_ws;
			src_data <= next_src_data;
			src_addr <= next_src_addr;
			dst_data <= next_dst_data;
			dest_address <= next_dest_address;
			step <= next_step;
			ovf <= next_ovf;
			busy <= next_busy;
			done <= next_done;
			div_overflow <= next_div_overflow;
			status_eq <= next_status_eq;
			derive_req <= next_derive_req;
			derive_dest <= next_derive_dest;
		end
	end

endmodule : instruction_cycle_sequencer

// *** sim/instruction_cycle_sequencer_chk.sv ***
// bus-cycle checker for the instruction cycle sequencer
`timescale 1ns/1ps
module seq_chk
	import seq_pkg::*;
(
	// clock and reset
	input wire logic         ref_clk,
	input wire logic         nrst,
	// request side
	input wire logic         start,
	input wire logic [15:0]  pc,
	input wire logic         busy,
	input wire logic         done,
	input wire logic         div_overflow,
	input wire logic [15:0]  instr_word,
	// derivation link
	input wire logic         derive_req,
	input wire logic         derive_done,
	input wire logic [15:0]  derive_addr,
	// memory bus
	input wire logic [15:0]  addr_bus,
	input wire logic         db_oe,
	input wire logic [15:0]  db_out,
	input wire logic [15:0]  db_in,
	input cycle_type_t       cycle_type
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	a_oe_on_write: assert property (db_oe == (cycle_type == CYC_WRITE))
		else $error("data bus enable outside a write cycle");
	a_fetch_first: assert property (start && !busy |=> cycle_type == CYC_READ
		&& addr_bus == $past(pc) ##1 cycle_type == CYC_ALU && $stable(addr_bus))
		else $error("fetch and decode cycles out of order");
	a_fetch_capture: assert property ($rose(busy) |=> instr_word == $past(db_in))
		else $error("fetched word not captured");
	a_read_alu_hold: assert property (cycle_type == CYC_ALU
		&& $past(cycle_type) == CYC_READ |-> $stable(addr_bus))
		else $error("address moved after a read");
	a_derive_idle: assert property (derive_req |-> cycle_type == CYC_NONE && busy)
		else $error("bus not released for derivation");
	a_derive_resume: assert property (busy && cycle_type == CYC_NONE && derive_done
		&& !derive_req |=> cycle_type == CYC_ALU && addr_bus == $past(derive_addr))
		else $error("no alu cycle after derivation");
	a_write_after_alu: assert property (cycle_type == CYC_WRITE
		|-> $past(cycle_type) == CYC_ALU)
		else $error("write not preceded by alu cycle");
	a_hi_lo_pair: assert property (cycle_type == CYC_WRITE ##1 cycle_type == CYC_ALU
		|-> addr_bus == $past(addr_bus) + WORD_STEP
		##1 cycle_type == CYC_WRITE && $stable(addr_bus))
		else $error("second half not at next word");
	a_ovf_abort: assert property (div_overflow |-> done && $past(cycle_type) == CYC_ALU
		&& $past(cycle_type, 2) == CYC_ALU && $past(cycle_type, 3) == CYC_READ)
		else $error("overflow abort at wrong cycle");
	a_done_ends: assert property ($fell(busy) |-> done && cycle_type == CYC_NONE)
		else $error("busy dropped without done");
	a_read_db_hold: assert property (cycle_type == CYC_READ |-> $stable(db_out))
		else $error("data bus moved in a read cycle");
endmodule : seq_chk

bind instruction_cycle_sequencer seq_chk u_chk (.ref_clk, .nrst, .start, .pc, .busy, .done,
	.div_overflow, .instr_word, .derive_req, .derive_done, .derive_addr, .addr_bus, .db_oe,
	.db_out, .db_in, .cycle_type);

// *** sim/mem_model.sv ***
// word-wide memory on the sequencer's address and data buses
`timescale 1ns/1ps
module mem_model
	import seq_pkg::*;
(
	// clock
	input wire logic         ref_clk,
	// bus
	input cycle_type_t       cycle_type,
	input wire logic [15:0]  addr_bus,
	input wire logic [15:0]  db_out,
	input wire logic         db_oe,
	output logic [15:0]      db_in
);
	logic [15:0] mem [0:255];
	logic [15:0] last;
	int          n_wr;
	initial begin
		last = 16'h0000;
		n_wr = 0;
	end
	// stale value is inverted so a late sample cannot pass
	assign db_in = (cycle_type == CYC_READ) ? mem[addr_bus[8:1]] : ~last;
	always @(posedge ref_clk) begin
		if (cycle_type == CYC_READ)
			last <= mem[addr_bus[8:1]];
		if (cycle_type == CYC_WRITE && db_oe) begin
			mem[addr_bus[8:1]] <= db_out;
			n_wr <= n_wr + 1;
		end
	end
endmodule : mem_model

// *** sim/instruction_cycle_sequencer_tb.sv ***
// self-checking bench for the instruction cycle sequencer
`timescale 1ns/1ps
module instruction_cycle_sequencer_tb
	import seq_pkg::*;
;
	logic        ref_clk, nrst, start, byte_op, busy, done, div_overflow, status_eq;
	logic        derive_req, derive_dest, derive_done, db_oe;
	logic [15:0] pc, ws_addr, instr_word, derive_addr, derive_data, addr_bus, db_out, db_in;
	logic [15:0] sa, sd, da, dd;
	op_class_t   op_class;
	alu_op_t     alu_op;
	cycle_type_t cycle_type;
	int          n_errors, n_compared, der_lat, dcnt, n_dest;
	logic [15:0] db_log [0:63];

	instruction_cycle_sequencer dut (.ref_clk(ref_clk), .nrst(nrst), .start(start),
		.op_class(op_class), .alu_op(alu_op), .byte_op(byte_op), .pc(pc), .ws_addr(ws_addr),
		.busy(busy), .done(done), .div_overflow(div_overflow), .status_eq(status_eq),
		.instr_word(instr_word), .derive_req(derive_req), .derive_dest(derive_dest),
		.derive_done(derive_done), .derive_addr(derive_addr), .derive_data(derive_data),
		.addr_bus(addr_bus), .db_out(db_out), .db_oe(db_oe), .db_in(db_in),
		.cycle_type(cycle_type));
	mem_model u_mem (.ref_clk(ref_clk), .cycle_type(cycle_type), .addr_bus(addr_bus),
		.db_out(db_out), .db_oe(db_oe), .db_in(db_in));

	always #25 ref_clk = ~ref_clk;

	// derivation engine answers der_lat + 1 cycles after a request
	always @(posedge ref_clk) begin
		if (!nrst) begin
			dcnt        <= 0;
			n_dest      <= 0;
			derive_done <= 1'b0;
			derive_addr <= 16'h0000;
			derive_data <= 16'h0000;
		end else begin
			derive_done <= (dcnt == 1) && !derive_req;
			derive_addr <= derive_dest ? da : sa;
			derive_data <= (dcnt == 1) ? (derive_dest ? dd : sd) : ~derive_data;
			if (derive_req) begin
				dcnt <= der_lat;
				n_dest <= n_dest + int'(derive_dest);
			end else if (dcnt != 0)
				dcnt <= dcnt - 1;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	task automatic run(input op_class_t c, input alu_op_t o, input logic b,
		output int cyc, output logic ovf);
		@(posedge ref_clk);
		start    <= 1'b1;
		op_class <= c;
		alu_op   <= o;
		byte_op  <= b;
		ws_addr  <= da;
		@(posedge ref_clk);
		start <= 1'b0;
		cyc = 0;
		ovf = 1'b0;
		for (int i = 0; i <= 300; i++) begin
			@(negedge ref_clk);
			if (busy === 1'b1) begin
				if (cyc < 64)
					db_log[cyc] = db_out;
				cyc++;
			end
			if (done === 1'b1) begin
				ovf = div_overflow;
				break;
			end
			if (i == 300) begin
				n_errors++;
				final_report();
			end
		end
	endtask : run

	task automatic t_two_op;
		int          cyc, n0, nd0;
		logic        ovf, nowr;
		logic [15:0] exp;
		sa = 16'h0100;
		sd = 16'h5A3C;
		da = 16'h0080;
		dd = 16'h0F0F;
		der_lat = 1;
		for (int k = 0; k <= 8; k++) begin
			u_mem.mem[8'h40] = dd;
			n0 = u_mem.n_wr;
			nd0 = n_dest;
			run(CLS_TWO_OPERAND, alu_op_t'(k), 1'b0, cyc, ovf);
			nowr = 1'b0;
			case (alu_op_t'(k))
				OP_ADD:       exp = dd + sd;
				OP_SUBTRACT:  exp = dd - sd;
				OP_SET_ONES:  exp = dd | sd;
				OP_SET_ZEROS: exp = dd & ~sd;
				OP_EXCL_OR:   exp = dd ^ sd;
				OP_COPY:      exp = sd;
				default: begin
					exp = dd;
					nowr = 1'b1;
				end
			endcase
			check(instr_word, 16'hC0DE);
			check(cyc, 11);
			check(n_dest - nd0, 1);
			if (nowr) check(status_eq, 1'b0);
			check(u_mem.mem[8'h40], exp);
			check(u_mem.n_wr - n0, nowr ? 0 : 1);
		end
		$display("test two_op finished");
	endtask : t_two_op

	task automatic t_copy_byte;
		int   cyc, n0;
		logic ovf;
		der_lat = 2;
		sd = 16'h12AB;
		for (int k = 0; k <= 1; k++) begin
			sa = (k == 0) ? 16'h0101 : 16'h0100;
			da = (k == 0) ? 16'h0080 : 16'h0081;
			u_mem.mem[8'h40] = dd;
			run(CLS_TWO_OPERAND, OP_COPY, 1'b1, cyc, ovf);
			check(cyc, 13);
			check(u_mem.mem[8'h40], (k == 0) ? {sd[7:0], dd[7:0]} : {dd[15:8], sd[15:8]});
		end
		sa = 16'h0100;
		da = 16'h0081;
		u_mem.mem[8'h40] = dd;
		run(CLS_TWO_OPERAND, OP_ADD, 1'b1, cyc, ovf);
		check(u_mem.mem[8'h40], {dd[15:8], dd[7:0] + sd[15:8]});
		sa = 16'h0101;
		da = 16'h0080;
		dd = 16'hAB0F;
		u_mem.mem[8'h40] = dd;
		n0 = u_mem.n_wr;
		run(CLS_TWO_OPERAND, OP_COMPARE, 1'b1, cyc, ovf);
		check(cyc, 13);
		check(status_eq, 1'b1);
		check(u_mem.n_wr - n0, 0);
		check(u_mem.mem[8'h40], dd);
		$display("test copy_byte finished");
	endtask : t_copy_byte

	task automatic t_mul_div;
		int          cyc, n0;
		logic        ovf;
		logic [31:0] prod;
		da = 16'h0020;
		der_lat = 1;
		sd = 16'h1234;
		u_mem.mem[8'h10] = 16'h0F0F;
		prod = 32'h0000_0F0F * 32'h0000_1234;
		run(CLS_MULTIPLY_OP, OP_ADD, 1'b0, cyc, ovf);
		check(cyc, 29);
		check(u_mem.mem[8'h10], prod[31:16]);
		check(u_mem.mem[8'h11], prod[15:0]);
		check(db_log[8], sd);
		check(db_log[26], prod[31:16]);
		check(db_log[27], prod[31:16]);
		sd = 16'h0100;
		u_mem.mem[8'h10] = 16'h0012;
		u_mem.mem[8'h11] = 16'h3456;
		run(CLS_DIVIDE, OP_ADD, 1'b0, cyc, ovf);
		check(cyc >= 48 && cyc <= 64, 1);
		check(ovf, 1'b0);
		check(u_mem.mem[8'h10], 16'h1234);
		check(u_mem.mem[8'h11], 16'h0056);
		check(db_log[7], sd);
		check(db_log[cyc - 3], 16'h1234);
		check(db_log[cyc - 1], 16'h0056);
		u_mem.mem[8'h10] = 16'h0200;
		n0 = u_mem.n_wr;
		run(CLS_DIVIDE, OP_ADD, 1'b0, cyc, ovf);
		check(cyc, 9);
		check(db_log[7], sd);
		check(ovf, 1'b1);
		check(u_mem.n_wr - n0, 0);
		$display("test mul_div finished");
	endtask : t_mul_div

	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		start = 1'b0;
		byte_op = 1'b0;
		op_class = CLS_TWO_OPERAND;
		alu_op = OP_ADD;
		pc = 16'h0040;
		ws_addr = 16'h0000;
		n_errors = 0;
		n_compared = 0;
		u_mem.mem[8'h20] = 16'hC0DE;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		t_two_op();
		t_copy_byte();
		t_mul_div();
		final_report();
	end
endmodule : instruction_cycle_sequencer_tb
